/* File: src/aocl_pkg.sv */
// Package for the analog output command logic: codes, defaults, register map.
// Assumes a 10 MHz system clock and a simple strobe-based register port.
package aocl_pkg;
  localparam int unsigned AOCL_CLK_HZ = 10000000;
  localparam int unsigned AOCL_NCH = 4;
  localparam int unsigned AOCL_DW = 16;
  // Output type codes
  localparam logic [1:0] AOCL_TYPE_UNUSED = 2'h0;
  localparam logic [1:0] AOCL_TYPE_CURRENT = 2'h1;
  localparam logic [1:0] AOCL_TYPE_VOLTAGE = 2'h2;
  // Control source codes
  localparam logic [3:0] AOCL_SRC_UNUSED = 4'h0;
  localparam logic [3:0] AOCL_SRC_ACIN = 4'h1;
  localparam logic [3:0] AOCL_SRC_MAX = 4'h9;
  // Control response codes
  localparam logic [1:0] AOCL_CRESP_SINGLE = 2'h0;
  localparam logic [1:0] AOCL_CRESP_OFF_BELOW = 2'h1;
  localparam logic [1:0] AOCL_CRESP_OFF_ABOVE = 2'h2;
  // Enable response codes
  localparam logic [2:0] AOCL_EN_ON_SHUT = 3'h0;
  localparam logic [2:0] AOCL_EN_ON_RAMP = 3'h1;
  localparam logic [2:0] AOCL_EN_ON_KEEP = 3'h2;
  localparam logic [2:0] AOCL_EN_OFF_SHUT = 3'h3;
  localparam logic [2:0] AOCL_EN_OFF_RAMP = 3'h4;
  localparam logic [2:0] AOCL_EN_OFF_KEEP = 3'h5;
  // Fault response codes
  localparam logic AOCL_FLT_HOLD = 1'b0;
  localparam logic AOCL_FLT_VALUE = 1'b1;
  // Timer: default 25 kHz output rate
  localparam int unsigned AOCL_PWM_HZ = 25000;
  localparam logic [15:0] AOCL_PWM_PERIOD = 16'(AOCL_CLK_HZ / AOCL_PWM_HZ);
  // Ramp tick is 1 ms
  localparam int unsigned AOCL_TICK_US = 1000;
  localparam logic [15:0] AOCL_TICK_CYC = 16'(AOCL_CLK_HZ / 1000000 * AOCL_TICK_US);
  // Type-dependent endpoint defaults (signed output units)
  localparam logic [15:0] AOCL_CUR_YMAX = 16'h4E20; // 20.000 mA in uA
  localparam logic [15:0] AOCL_VOL_YMAX = 16'h2710; // 10.000 V in mV
  localparam logic [15:0] AOCL_XMAX_DEF = 16'h03E8;
  localparam logic [15:0] AOCL_ZERO = 16'h0000;
  // Register map: index field of address = [6:4] channel, [3:0] register
  localparam logic [3:0] AOCL_R_TYPE = 4'h0;
  localparam logic [3:0] AOCL_R_SRC = 4'h1;
  localparam logic [3:0] AOCL_R_MODES = 4'h2;
  localparam logic [3:0] AOCL_R_XMIN = 4'h3;
  localparam logic [3:0] AOCL_R_XMAX = 4'h4;
  localparam logic [3:0] AOCL_R_YMIN = 4'h5;
  localparam logic [3:0] AOCL_R_YMAX = 4'h6;
  localparam logic [3:0] AOCL_R_YOVR = 4'h7;
  localparam logic [3:0] AOCL_R_YFLT = 4'h8;
  localparam logic [3:0] AOCL_R_RUP = 4'h9;
  localparam logic [3:0] AOCL_R_RDN = 4'hA;
  localparam logic [3:0] AOCL_R_PER = 4'hB;
  localparam logic [3:0] AOCL_R_DUTY = 4'hC;
  localparam logic [3:0] AOCL_R_SLOPE = 4'hD;
  localparam logic [3:0] AOCL_R_OUT = 4'hE;
  localparam logic [3:0] AOCL_R_GLOBAL = 4'hF;
  // MODES fields
  localparam int unsigned AOCL_M_CRESP = 0;
  localparam int unsigned AOCL_M_ENRESP = 2;
  localparam int unsigned AOCL_M_OVPOL = 5;
  localparam int unsigned AOCL_M_FLT = 6;
  localparam int unsigned AOCL_M_ENSRC = 8;
  localparam int unsigned AOCL_M_OVSRC = 12;
  localparam logic [15:0] AOCL_MODES_RST = 16'h0040;
  // SRC fields
  localparam int unsigned AOCL_S_SRC = 0;
  localparam int unsigned AOCL_S_NUM = 4;
endpackage

/* File: src/aocl_ramp.sv */
// Rate limiter for one channel: moves the output toward a target by a step
// each 1 ms tick. Assumes step values are precomputed by the caller.
`timescale 1ns/1ps
module aocl_ramp
  import aocl_pkg::*;
#(
  parameter int unsigned DW = AOCL_DW
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic tick_in,
  input wire logic signed [DW-1:0] target_in,
  input wire logic [DW-1:0] step_up_in,
  input wire logic [DW-1:0] step_dn_in,
  input wire logic hold_in,
  output logic signed [DW-1:0] value_out
);
  logic signed [DW:0] diff;
  logic signed [DW-1:0] value_nxt;

  // Step toward the target; zero step means jump at once
  always_comb begin
    diff = {target_in[DW-1], target_in} - {value_out[DW-1], value_out};
    value_nxt = value_out;
    if (!hold_in && diff > 0) begin
      if (step_up_in == '0 || diff <= $signed({1'b0, step_up_in})) begin
        value_nxt = target_in;
      end else if (tick_in) begin
        value_nxt = value_out + $signed(step_up_in);
      end
    end else if (!hold_in && diff < 0) begin
      if (step_dn_in == '0 || -diff <= $signed({1'b0, step_dn_in})) begin
        value_nxt = target_in;
      end else if (tick_in) begin
        value_nxt = value_out - $signed(step_dn_in);
      end
    end
  end

  // Output register
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      value_out <= '0;
    end else begin
      value_out <= value_nxt; // RQ7
    end
  end
endmodule

/* File: src/aocl_timer.sv */
// Independent fixed-frequency output timer for one channel.
// Assumes period and duty come from registers on the same clock.
`timescale 1ns/1ps
module aocl_timer
  import aocl_pkg::*;
#(
  parameter int unsigned DW = AOCL_DW
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic run_in,
  input wire logic [DW-1:0] period_in,
  input wire logic [DW-1:0] duty_in,
  output logic pwm_out
);
  logic [DW-1:0] cnt_r;

  // Free-running counter wrapping at its own period
  always_ff @(posedge clk_in) begin
    if (!rstn_in || !run_in) begin
      cnt_r <= '0;
    end else if (cnt_r + DW'(1) >= period_in) begin
      cnt_r <= '0; // RQ6
    end else begin
      cnt_r <= cnt_r + DW'(1);
    end
  end

  // Output high while count is below duty
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= run_in && (cnt_r < duty_in); // RQ5
    end
  end
endmodule

/* File: src/aocl_top.sv */
// Analog output command logic: four channels with scaling, clamping,
// ramping, enable, override, fault and overtemperature handling.
// Assumes outside levels are synchronised here and a strobe
// register port on the same clock.
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// RQ1 - Per-channel output type: 0 unused, 1 current, 2 voltage; reset to 2.
// RQ2 - Writing output type reloads that channel's dependent settings.
// RQ3 - Output equals slope times input plus intercept from endpoints.
// RQ4 - Input min below max; output endpoints unordered, negative slopes allowed.
// RQ5 - Output timer runs 25 kHz by default; period/duty settable.
// RQ6 - Each channel has its own timer, changeable without disturbing others.
// RQ7 - Separate rise/fall ramp steps per ms tick; zero means immediate.
// RQ8 - Source code 0..9 plus number selects the channel's driving signal.
// RQ9 - Default control source is the AC input of the same channel.
// RQ10 - Out-of-range input drives the endpoint output, no extrapolation.
// RQ11 - Control response: 0 clamped, 1 off below min, 2 off above max.
// RQ12 - Enable response 0..2 on-active, 3..5 off-active: shut, ramp, keep.
// RQ13 - Disable-type codes turn output off while enable input is on.
// RQ14 - Active override drives override value; polarity 0 on, 1 off.
// RQ15 - Enable and override sources use the control source list.
// RQ16 - On input error: code 0 holds, code 1 drives fault value (default).
// RQ17 - Enabled overtemperature fault disables outputs until it clears; here only the setpoint targets go to zero, PWM timers keep running.
// RQ18 - Order: fault, then enable, then override, then control.
// RQ19 - Configuring party sets output endpoints to select output range.
// RQ20 - Rampoff falls to off value at fall rate; zero ramp is immediate.
module aocl_top
  import aocl_pkg::*;
#(
  parameter int unsigned NCH = AOCL_NCH,
  parameter int unsigned DW = AOCL_DW,
  parameter int unsigned NSRC = 16
) (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [DW-1:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [DW-1:0] RDATA_OUT,
  input wire logic [NSRC*DW-1:0] SRC_VAL_IN,
  input wire logic [NSRC-1:0] SRC_ERR_IN,
  input wire logic OVERTEMP_IN,
  output logic [NCH*DW-1:0] SETPOINT_OUT,
  output logic [NCH-1:0] PWM_OUT
);
  // Per-channel settings
  logic [1:0] type_r [NCH];
  logic [DW-1:0] src_r [NCH];
  logic [DW-1:0] modes_r [NCH];
  logic signed [DW-1:0] xmin_r [NCH];
  logic signed [DW-1:0] xmax_r [NCH];
  logic signed [DW-1:0] ymin_r [NCH];
  logic signed [DW-1:0] ymax_r [NCH];
  logic signed [DW-1:0] yovr_r [NCH];
  logic signed [DW-1:0] yflt_r [NCH];
  logic [DW-1:0] rup_r [NCH];
  logic [DW-1:0] rdn_r [NCH];
  logic [DW-1:0] per_r [NCH];
  logic [DW-1:0] duty_r [NCH];
  logic ot_en_r;
  logic ot_s1_r;
  logic ot_s2_r;
  logic [NSRC*DW-1:0] sv_s1_r;
  logic [NSRC*DW-1:0] sv_s2_r;
  logic [NSRC-1:0] se_s1_r;
  logic [NSRC-1:0] se_s2_r;
  logic [15:0] tick_cnt_r;
  logic tick_r;
  logic signed [DW-1:0] ramp_val [NCH];
  logic signed [DW-1:0] slope_w [NCH];
  logic [3:0] addr_ch;
  logic [3:0] addr_reg;
  logic [DW-1:0] rdata_nxt;
  logic [1:0] rc;

  assign addr_ch = {1'b0, ADDR_IN[6:4]};
  assign rc = addr_ch[1:0];
  assign addr_reg = ADDR_IN[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for outside levels
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      ot_s1_r <= 1'b0;
      ot_s2_r <= 1'b0;
      sv_s1_r <= '0;
      sv_s2_r <= '0;
      se_s1_r <= '0;
      se_s2_r <= '0;
    end else begin
      ot_s1_r <= OVERTEMP_IN;
      ot_s2_r <= ot_s1_r;
      sv_s1_r <= SRC_VAL_IN;
      sv_s2_r <= sv_s1_r;
      se_s1_r <= SRC_ERR_IN;
      se_s2_r <= se_s1_r;
    end
  end

  // 1 ms ramp tick
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (tick_cnt_r + 16'h0001 >= AOCL_TICK_CYC) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // Global overtemperature enable, written at any channel's GLOBAL offset
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      ot_en_r <= 1'b0;
    end else if (WR_IN && addr_reg == AOCL_R_GLOBAL) begin
      ot_en_r <= WDATA_IN[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel logic
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic wr_ch;
    logic [3:0] csrc;
    logic [3:0] cnum;
    logic [3:0] esrc;
    logic [3:0] osrc;
    logic [1:0] cresp;
    logic [2:0] enresp;
    logic ovpol;
    logic fresp;
    logic signed [DW-1:0] x;
    logic signed [DW-1:0] ex;
    logic signed [DW-1:0] ox;
    logic err;
    logic en_on;
    logic ov_on;
    logic enabled;
    logic signed [DW-1:0] lin;
    logic signed [DW-1:0] target;
    logic hold;
    logic [DW-1:0] sup;
    logic [DW-1:0] sdn;
    logic signed [2*DW+1:0] num;
    logic signed [DW:0] dx;
    logic signed [DW:0] dy;
    logic [DW-1:0] yrange;

    assign wr_ch = WR_IN && addr_ch == 4'(c);
    assign csrc = src_r[c][AOCL_S_SRC +: 4];
    assign cnum = src_r[c][AOCL_S_NUM +: 4];
    assign cresp = modes_r[c][AOCL_M_CRESP +: 2];
    assign enresp = modes_r[c][AOCL_M_ENRESP +: 3];
    assign ovpol = modes_r[c][AOCL_M_OVPOL];
    assign fresp = modes_r[c][AOCL_M_FLT];
    assign esrc = modes_r[c][AOCL_M_ENSRC +: 4];
    assign osrc = modes_r[c][AOCL_M_OVSRC +: 4];

    // Source selection: code and number form an index into source values
    assign x = sv_s2_r[4'(csrc + cnum)*DW +: DW]; // RQ8
    assign ex = sv_s2_r[esrc*DW +: DW]; // RQ15
    assign ox = sv_s2_r[osrc*DW +: DW]; // RQ15
    assign en_on = (esrc != AOCL_SRC_UNUSED) && (ex != '0);
    assign ov_on = (osrc != AOCL_SRC_UNUSED) && ((ox != '0) ^ ovpol); // RQ14
    assign err = (csrc != AOCL_SRC_UNUSED && se_s2_r[4'(csrc + cnum)])
               || (esrc != AOCL_SRC_UNUSED && se_s2_r[esrc])
               || (osrc != AOCL_SRC_UNUSED && se_s2_r[osrc]);

    // Enable: codes 0..2 active on, 3..5 active off
    always_comb begin
      if (esrc == AOCL_SRC_UNUSED) begin
        enabled = 1'b1;
      end else if (enresp >= AOCL_EN_OFF_SHUT) begin
        enabled = !en_on; // RQ13
      end else begin
        enabled = en_on; // RQ12
      end
    end

    // Linear scaling with clamping
    always_comb begin
      dx = {xmax_r[c][DW-1], xmax_r[c]} - {xmin_r[c][DW-1], xmin_r[c]};
      dy = {ymax_r[c][DW-1], ymax_r[c]} - {ymin_r[c][DW-1], ymin_r[c]};
      num = (2*DW+2)'(dy) * (2*DW+2)'($signed({x[DW-1], x} - {xmin_r[c][DW-1], xmin_r[c]}));
      if (x <= xmin_r[c]) begin
        lin = ymin_r[c]; // RQ10
      end else if (x >= xmax_r[c]) begin
        lin = ymax_r[c]; // RQ10
      end else begin
        lin = ymin_r[c] + DW'(num / (2*DW+2)'(dx)); // RQ3 RQ4
      end
    end
    assign slope_w[c] = (dx > 0) ? DW'(dy / dx) : '0;

    // Priority: overtemp, fault, enable, override, control
    always_comb begin
      target = lin;
      hold = 1'b0;
      if (type_r[c] == AOCL_TYPE_UNUSED || csrc == AOCL_SRC_UNUSED) begin
        target = AOCL_ZERO;
      end else if (ot_en_r && ot_s2_r) begin
        target = AOCL_ZERO; // RQ17
      end else if (err) begin
        if (fresp == AOCL_FLT_HOLD) begin
          hold = 1'b1; // RQ16
        end else begin
          target = yflt_r[c]; // RQ16 RQ18
        end
      end else if (!enabled) begin
        target = AOCL_ZERO; // RQ12 RQ18
        hold = (enresp == AOCL_EN_ON_KEEP) || (enresp == AOCL_EN_OFF_KEEP);
      end else if (ov_on) begin
        target = yovr_r[c]; // RQ14 RQ18
      end else if (cresp == AOCL_CRESP_OFF_BELOW && x < xmin_r[c]) begin
        target = AOCL_ZERO; // RQ11
      end else if (cresp == AOCL_CRESP_OFF_ABOVE && x > xmax_r[c]) begin
        target = AOCL_ZERO; // RQ11
      end
    end

    // Step sizes: range over ramp ms; a zero ramp time or an enable shut code bypasses the ramp
    assign yrange = (dy < 0) ? DW'(-dy) : DW'(dy);
    always_comb begin
      sup = (rup_r[c] == '0) ? '0 : DW'(yrange / rup_r[c]); // RQ7
      sdn = (rdn_r[c] == '0) ? '0 : DW'(yrange / rdn_r[c]); // RQ7
      if (sup == '0 && rup_r[c] != '0) sup = DW'(1);
      if (sdn == '0 && rdn_r[c] != '0) sdn = DW'(1);
      if (enabled == 1'b0 && !err && esrc != AOCL_SRC_UNUSED
          && (enresp == AOCL_EN_ON_SHUT || enresp == AOCL_EN_OFF_SHUT)) begin
        sup = '0;
        sdn = '0;
      end
      // Rampoff keeps the fall rate toward zero
      if (!enabled && (enresp == AOCL_EN_ON_RAMP || enresp == AOCL_EN_OFF_RAMP)) begin
        sup = sdn; // RQ20
      end
    end

    aocl_ramp #(.DW(DW)) u_ramp (
      .clk_in(CLK_IN),
      .rstn_in(RSTN_IN),
      .tick_in(tick_r),
      .target_in(target),
      .step_up_in(sup),
      .step_dn_in(sdn),
      .hold_in(hold),
      .value_out(ramp_val[c])
    );

    aocl_timer #(.DW(DW)) u_timer (
      .clk_in(CLK_IN),
      .rstn_in(RSTN_IN),
      .run_in(type_r[c] != AOCL_TYPE_UNUSED),
      .period_in(per_r[c]),
      .duty_in(duty_r[c]),
      .pwm_out(PWM_OUT[c])
    );

    // Setpoint output register
    always_ff @(posedge CLK_IN) begin
      if (!RSTN_IN) begin
        SETPOINT_OUT[c*DW +: DW] <= '0;
      end else begin
        SETPOINT_OUT[c*DW +: DW] <= ramp_val[c];
      end
    end

    // Type register; a type write reloads dependent settings
    always_ff @(posedge CLK_IN) begin
      if (!RSTN_IN) begin
        type_r[c] <= AOCL_TYPE_VOLTAGE; // RQ1
        ymin_r[c] <= AOCL_ZERO;
        ymax_r[c] <= AOCL_VOL_YMAX;
        yovr_r[c] <= AOCL_ZERO;
        yflt_r[c] <= AOCL_ZERO;
        rup_r[c] <= '0;
        rdn_r[c] <= '0;
        per_r[c] <= AOCL_PWM_PERIOD; // RQ5
        duty_r[c] <= '0;
      end else if (wr_ch && addr_reg == AOCL_R_TYPE) begin
        type_r[c] <= WDATA_IN[1:0];
        ymin_r[c] <= AOCL_ZERO; // RQ2
        ymax_r[c] <= (WDATA_IN[1:0] == AOCL_TYPE_CURRENT) ? AOCL_CUR_YMAX
                   : (WDATA_IN[1:0] == AOCL_TYPE_VOLTAGE) ? AOCL_VOL_YMAX : AOCL_ZERO;
        yovr_r[c] <= AOCL_ZERO;
        yflt_r[c] <= AOCL_ZERO;
        rup_r[c] <= '0;
        rdn_r[c] <= '0;
        per_r[c] <= AOCL_PWM_PERIOD;
        duty_r[c] <= '0;
      end else if (wr_ch) begin
        if (addr_reg == AOCL_R_YMIN) ymin_r[c] <= WDATA_IN; // RQ19
        if (addr_reg == AOCL_R_YMAX) ymax_r[c] <= WDATA_IN; // RQ19
        if (addr_reg == AOCL_R_YOVR) yovr_r[c] <= WDATA_IN;
        if (addr_reg == AOCL_R_YFLT) yflt_r[c] <= WDATA_IN;
        if (addr_reg == AOCL_R_RUP) rup_r[c] <= WDATA_IN;
        if (addr_reg == AOCL_R_RDN) rdn_r[c] <= WDATA_IN;
        if (addr_reg == AOCL_R_PER) per_r[c] <= WDATA_IN; // RQ6
        if (addr_reg == AOCL_R_DUTY) duty_r[c] <= WDATA_IN;
      end
    end

    // Source, mode and input range registers
    always_ff @(posedge CLK_IN) begin
      if (!RSTN_IN) begin
        src_r[c] <= {8'h00, 4'(c), AOCL_SRC_ACIN}; // RQ9
        modes_r[c] <= AOCL_MODES_RST; // RQ16
        xmin_r[c] <= AOCL_ZERO;
        xmax_r[c] <= AOCL_XMAX_DEF;
      end else if (wr_ch) begin
        if (addr_reg == AOCL_R_SRC && WDATA_IN[3:0] <= AOCL_SRC_MAX) src_r[c] <= WDATA_IN;
        if (addr_reg == AOCL_R_MODES) modes_r[c] <= WDATA_IN;
        // Keep xmin strictly below xmax
        if (addr_reg == AOCL_R_XMIN && $signed(WDATA_IN) < xmax_r[c]) xmin_r[c] <= WDATA_IN;
        if (addr_reg == AOCL_R_XMAX && $signed(WDATA_IN) > xmin_r[c]) xmax_r[c] <= WDATA_IN;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  always_comb begin
    rdata_nxt = '0;
    if (addr_ch < 4'(NCH)) begin
      unique case (addr_reg)
        AOCL_R_TYPE: rdata_nxt = {14'h0000, type_r[rc]};
        AOCL_R_SRC: rdata_nxt = src_r[rc];
        AOCL_R_MODES: rdata_nxt = modes_r[rc];
        AOCL_R_XMIN: rdata_nxt = xmin_r[rc];
        AOCL_R_XMAX: rdata_nxt = xmax_r[rc];
        AOCL_R_YMIN: rdata_nxt = ymin_r[rc];
        AOCL_R_YMAX: rdata_nxt = ymax_r[rc];
        AOCL_R_YOVR: rdata_nxt = yovr_r[rc];
        AOCL_R_YFLT: rdata_nxt = yflt_r[rc];
        AOCL_R_RUP: rdata_nxt = rup_r[rc];
        AOCL_R_RDN: rdata_nxt = rdn_r[rc];
        AOCL_R_PER: rdata_nxt = per_r[rc];
        AOCL_R_DUTY: rdata_nxt = duty_r[rc];
        AOCL_R_SLOPE: rdata_nxt = slope_w[rc];
        AOCL_R_OUT: rdata_nxt = ramp_val[rc];
        AOCL_R_GLOBAL: rdata_nxt = {14'h0000, ot_s2_r, ot_en_r};
      endcase
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      RDATA_OUT <= '0;
    end else begin
      RDATA_OUT <= RD_IN ? rdata_nxt : '0;
    end
  end
endmodule

/* File: test/aocl_top_properties.sv */
// Checker for the analog output command logic, seen from its top ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module aocl_chk
  import aocl_pkg::*;
#(
  parameter int unsigned NCH = AOCL_NCH,
  parameter int unsigned DW = AOCL_DW
) (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [DW-1:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [DW-1:0] RDATA_OUT,
  input wire logic OVERTEMP_IN,
  input wire logic [NCH*DW-1:0] SETPOINT_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  logic ot_en_r;
  logic [2:0] ch_r;
  wire [3:0] idx = ADDR_IN[3:0];
  wire same = ADDR_IN[6:4] == ch_r;
  // Channel of the previous request
  always_ff @(posedge CLK_IN) begin
    ch_r <= ADDR_IN[6:4];
  end
  // Overtemperature enable as last written
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) ot_en_r <= 1'b0;
    else if (WR_IN && idx == AOCL_R_GLOBAL) ot_en_r <= WDATA_IN[0];
  end
  // Endpoint reloaded for each output type
  function automatic logic [15:0] ymax_of(logic [15:0] t);
    return t == 16'h0001 ? AOCL_CUR_YMAX : (t == 16'h0002 ? AOCL_VOL_YMAX : AOCL_ZERO);
  endfunction
  sequence s_type_wr;
    WR_IN && !ADDR_IN[6] && idx == AOCL_R_TYPE && WDATA_IN <= 16'h0002;
  endsequence
  sequence s_src_ok;
    WR_IN && !ADDR_IN[6] && idx == AOCL_R_SRC && WDATA_IN[3:0] <= AOCL_SRC_MAX;
  endsequence
  sequence s_src_bad;
    WR_IN && same && idx == AOCL_R_SRC && WDATA_IN[3:0] > AOCL_SRC_MAX;
  endsequence
  sequence s_xmax_ok;
    WR_IN && !ADDR_IN[6] && idx == AOCL_R_XMAX ##1 RD_IN && ADDR_IN == $past(ADDR_IN)
    ##1 RDATA_OUT == $past(WDATA_IN, 2);
  endsequence
  property p_rd_idle;
    !$past(RD_IN) |-> RDATA_OUT == '0;
  endproperty
  property p_rd_badch;
    RD_IN && ADDR_IN[6] && idx != AOCL_R_GLOBAL |=> RDATA_OUT == '0;
  endproperty
  property p_rw_echo;
    WR_IN && !ADDR_IN[6] && idx inside {[4'h5:4'hA]} ##1 RD_IN && ADDR_IN == $past(ADDR_IN)
    |=> RDATA_OUT == $past(WDATA_IN, 2);
  endproperty
  property p_type_reload;
    s_type_wr ##1 (RD_IN && same && idx == AOCL_R_YMAX)
    |=> RDATA_OUT == ymax_of($past(WDATA_IN, 2));
  endproperty
  property p_src_refuse;
    s_src_ok ##1 s_src_bad ##1 (RD_IN && ADDR_IN == $past(ADDR_IN))
    |=> RDATA_OUT == $past(WDATA_IN, 3);
  endproperty
  property p_xmin_refuse;
    s_xmax_ok ##0 (WR_IN && same && idx == AOCL_R_XMIN && $signed(WDATA_IN) < $signed(RDATA_OUT))
    ##1 (WR_IN && same && idx == AOCL_R_XMIN && $signed(WDATA_IN) >= $signed($past(RDATA_OUT)))
    ##1 (RD_IN && same && idx == AOCL_R_XMIN) |=> RDATA_OUT == $past(WDATA_IN, 3);
  endproperty
  property p_ot_off;
    (ot_en_r && OVERTEMP_IN) [*6] |-> SETPOINT_OUT == '0;
  endproperty
  property p_ot_flag;
    $stable(OVERTEMP_IN) [*4] ##0 (RD_IN && idx == AOCL_R_GLOBAL)
    |=> RDATA_OUT[1] == $past(OVERTEMP_IN);
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not cleared");
  a_rd_badch: assert property (p_rd_badch)
    else $error("missing channel read not zero");
  a_rw_echo: assert property (p_rw_echo)
    else $error("setting not read back");
  a_type_reload: assert property (p_type_reload)
    else $error("type write did not reload endpoint");
  a_src_refuse: assert property (p_src_refuse)
    else $error("bad source code taken");
  a_xmin_refuse: assert property (p_xmin_refuse)
    else $error("input minimum not refused");
  a_ot_off: assert property (p_ot_off)
    else $error("outputs live in overtemperature");
  a_ot_flag: assert property (p_ot_flag)
    else $error("overtemperature flag wrong");
endmodule

/* File: test/aocl_load.sv */
// Load model: measures each output timer period between rising edges.
// Assumes the timer outputs change on the system clock.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module aocl_load (
  input wire logic clk_in,
  input wire logic [3:0] pwm_in,
  output logic [15:0] per_out [4]
);
  logic [15:0] cnt [4] = '{default: 16'h0000};
  logic [3:0] prv = 4'h0;
  // Count clocks between rising edges of each timer
  always @(posedge clk_in) begin
    prv <= pwm_in;
    for (int c = 0; c < 4; c++) begin
      if (pwm_in[c] && !prv[c]) begin
        per_out[c] <= cnt[c];
        cnt[c] <= 16'h0001;
      end else begin
        cnt[c] <= cnt[c] + 16'h0001;
      end
    end
  end
endmodule

/* File: test/aocl_top_tb.sv */
// Self-checking bench for the analog output command logic.
// Assumes the load model and the port checker compiled beforehand.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %0t got %h exp %h", $time, g, e); end end
module aocl_top_tb
  import aocl_pkg::*;
;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, ot = 1'b0, pend = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wd = 16'h0000, pexp = 16'h0000, se = 16'h0000, rdo;
  logic [255:0] sv = '0;
  logic [63:0] spo;
  logic [3:0] pwm;
  logic [15:0] per [4];
  int fails = 0, samples_checked = 0, seed = 32'h8780;
  int yn [4] = '{0, 10000, 1000, 0}, yx [4] = '{10000, -10000, 10000, 10000};
  int cr [4] = '{0, 0, 0, 0}, cx [4] = '{-1, 0, 1000, 1001}, x [4];
  // Clock of 100 ns
  initial forever #50 clk = ~clk;
  aocl_top dut (.CLK_IN(clk), .RSTN_IN(rstn), .ADDR_IN(addr), .WDATA_IN(wd), .WR_IN(wr),
    .RD_IN(rd), .RDATA_OUT(rdo), .SRC_VAL_IN(sv), .SRC_ERR_IN(se), .OVERTEMP_IN(ot),
    .SETPOINT_OUT(spo), .PWM_OUT(pwm));
  aocl_load load (.clk_in(clk), .pwm_in(pwm), .per_out(per));
  ////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [7:0] ad(int c, logic [3:0] r);
    return {c[3:0], r};
  endfunction
  function automatic logic [15:0] sp(int c);
    return spo[c*16 +: 16];
  endfunction
  // Clamped linear response for input range 0..1000
  function automatic logic [15:0] lin(int v, int c);
    if (v < 0) return cr[c] == 1 ? 16'h0000 : 16'(yn[c]);
    if (v > 1000) return cr[c] == 2 ? 16'h0000 : 16'(yx[c]);
    return 16'(yn[c] + (yx[c] - yn[c]) * v / 1000);
  endfunction
  // One bus cycle; checks the read data of the previous cycle
  task op(logic w, r, logic [7:0] a, logic [15:0] d, e);
    @(posedge clk);
    wr <= w;
    rd <= r;
    addr <= a;
    wd <= d;
    #1;
    if (pend) `CHK(rdo, pexp)
    pend = r;
    pexp = e;
  endtask
  task cyc(int n);
    repeat (n) op('0, '0, '0, '0, '0);
  endtask
  task wt(int c, logic [3:0] a, logic [15:0] d);
    op('1, '0, ad(c, a), d, '0);
  endtask
  task rt(int c, logic [3:0] a, logic [15:0] e);
    op('0, '1, ad(c, a), '0, e);
  endtask
  task sx(int s, int v);
    sv[s*16 +: 16] = 16'(v);
  endtask
  task results;
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      rt(c, AOCL_R_TYPE, {14'h0, AOCL_TYPE_VOLTAGE});
      rt(c, AOCL_R_SRC, 16'(c * 16 + 1));
      rt(c, AOCL_R_PER, AOCL_PWM_PERIOD);
      rt(c, AOCL_R_MODES, AOCL_MODES_RST);
    end
    rt(5, AOCL_R_TYPE, '0);
    for (int k = 0; k < 10; k++) begin
      wt(3, AOCL_R_SRC, 16'(k));
      rt(3, AOCL_R_SRC, 16'(k));
    end
    wt(3, AOCL_R_SRC, 16'h0031);
    wt(0, AOCL_R_SRC, 16'h0001);
    wt(0, AOCL_R_SRC, 16'h000A);
    rt(0, AOCL_R_SRC, 16'h0001);
    wt(1, AOCL_R_XMAX, AOCL_XMAX_DEF);
    rt(1, AOCL_R_XMAX, AOCL_XMAX_DEF);
    wt(1, AOCL_R_XMIN, '0);
    wt(1, AOCL_R_XMIN, AOCL_XMAX_DEF);
    rt(1, AOCL_R_XMIN, '0);
    for (int t = 0; t < 3; t++) begin
      wt(2, AOCL_R_RUP, 16'h0005);
      wt(2, AOCL_R_TYPE, 16'(t));
      rt(2, AOCL_R_YMAX, t == 1 ? AOCL_CUR_YMAX : (t == 2 ? AOCL_VOL_YMAX : '0));
      rt(2, AOCL_R_RUP, '0);
    end
    wt(1, AOCL_R_YMIN, 16'h2710);
    rt(1, AOCL_R_YMIN, 16'h2710);
    wt(1, AOCL_R_YMAX, 16'hD8F0);
    wt(2, AOCL_R_YMIN, 16'h03E8);
    for (int i = 0; i < 40; i++) begin
      cr[2] = i % 3;
      wt(2, AOCL_R_MODES, 16'(64 + cr[2]));
      for (int c = 0; c < 4; c++) begin
        x[c] = i < 4 ? cx[i] : ($random(seed) & 2047) - 400;
        sx(c + 1, x[c]);
      end
      cyc(6);
      for (int c = 0; c < 4; c++) `CHK(sp(c), lin(x[c], c))
    end
    for (int r = 0; r < 6; r++) begin
      wt(3, AOCL_R_MODES, 16'(16'h0F40 + r * 4));
      sx(15, r < 3);
      sx(4, 500);
      cyc(6);
      `CHK(sp(3), 16'h1388)
      sx(15, r >= 3);
      sx(4, 800);
      cyc(6);
      `CHK(sp(3), r % 3 == 2 ? 16'h1388 : 16'h0000)
    end
    wt(3, AOCL_R_YOVR, 16'h04D2);
    for (int p = 0; p < 2; p++) begin
      wt(3, AOCL_R_MODES, 16'(16'hE040 + p * 32));
      sx(14, p == 0);
      cyc(6);
      `CHK(sp(3), 16'h04D2)
      sx(14, p == 1);
      cyc(6);
      `CHK(sp(3), 16'h1F40)
    end
    wt(3, AOCL_R_MODES, 16'h0000);
    sx(4, 300);
    cyc(6);
    se[4] = 1'b1;
    sx(4, 900);
    cyc(6);
    `CHK(sp(3), 16'h0BB8)
    se[4] = 1'b0;
    wt(3, AOCL_R_YFLT, 16'h0077);
    wt(3, AOCL_R_MODES, 16'hE040);
    sx(14, 1);
    se[4] = 1'b1;
    cyc(6);
    `CHK(sp(3), 16'h0077)
    se[4] = 1'b0;
    wt(0, AOCL_R_GLOBAL, 16'h0001);
    ot = 1'b1;
    cyc(6);
    rt(0, AOCL_R_GLOBAL, 16'h0003);
    `CHK(spo, 64'h0)
    ot = 1'b0;
    cyc(6);
    `CHK(sp(3), 16'h04D2)
    wt(0, AOCL_R_RUP, 16'h0002);
    sx(1, 0);
    cyc(6);
    sx(1, 1000);
    cyc(6);
    `CHK($signed(sp(0)) <= 5000, 1'b1)
    cyc(20000);
    `CHK(sp(0), 16'h2710)
    for (int c = 0; c < 4; c++) wt(c, AOCL_R_DUTY, 16'h0064);
    wt(1, AOCL_R_PER, 16'h00C8);
    cyc(1000);
    `CHK(per[0], AOCL_PWM_PERIOD)
    `CHK(per[1], 16'h00C8)
    `CHK(per[3], AOCL_PWM_PERIOD)
    results();
  end
  // Guard against a hang
  initial begin
    #5000000;
    fails++;
    results();
  end
endmodule
bind aocl_top aocl_chk #(.NCH(NCH), .DW(DW)) u_chk (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN),
  .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
  .RDATA_OUT(RDATA_OUT), .OVERTEMP_IN(OVERTEMP_IN), .SETPOINT_OUT(SETPOINT_OUT));
